// file: ratio_boost_pkg.sv
// package: register map, field layout and reset values for the ratio and boost config bank
package ratio_boost_pkg;

    // register offsets on the control port
    localparam logic [7:0] ADDR_CLOCK_RATIO_CONFIG   = 8'h14;
    localparam logic [7:0] ADDR_BOOST_CONFIG_A       = 8'h15;
    localparam logic [7:0] ADDR_BOOST_CONFIG_B       = 8'h16;
    localparam logic [7:0] ADDR_SOFTWARE_RESET_CMD   = 8'hff;
    localparam logic [7:0] ADDR_FAULT_CONTROL        = 8'h12;

    // value that starts a soft reset
    localparam logic [7:0] SOFT_RESET_KEY            = 8'h00;

    // reset values
    localparam logic [7:0] RST_CLOCK_RATIO_CONFIG    = 8'h11;
    localparam logic [7:0] RST_BOOST_CONFIG_A        = 8'h03;
    localparam logic [7:0] RST_BOOST_CONFIG_B        = 8'h00;

    // field positions
    localparam int AUTO_RATIO_BIT   = 4;
    localparam int RATIO_CODE_MSB   = 3;
    localparam int DRIVE_SPEED_LSB  = 6;
    localparam int DISCHARGE_BIT    = 2;
    localparam int PWM_ONLY_N_BIT   = 1;
    localparam int FREQ_SEL_BIT     = 0;
    localparam int MANUAL_RCV_BIT   = 3;
    localparam int GM_SEL_LSB       = 0;
    localparam int MANUAL_TRIG_BIT  = 3;

    // largest legal ratio code (400 x fs)
    localparam logic [3:0] RATIO_CODE_MAX = 4'h9;

    // one-hot ratio decode width, one per legal code
    localparam int RATIO_SEL_WIDTH  = 10;

    // register bus write/read request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_type;

    // control bits toward the analog boost
    typedef struct packed {
        logic [1:0] highSideDriveSpeed;
        logic       dischargeSwitchEn;
        logic       pwmOnlyN;
        logic       boostFreqSel;
        logic       boostFaultManualRecovery;
        logic [1:0] errorAmpGmSel;
    } boost_ctrl_type;

endpackage : ratio_boost_pkg

// file: ratio_code_decoder.sv
// leaf: one-hot decode of the clock ratio code
`timescale 1ns/100ps
module ratio_code_decoder
    import ratio_boost_pkg::*;
(
    input  wire logic [3:0]                 ratioCode,   // active ratio code
    output logic      [RATIO_SEL_WIDTH-1:0] ratioSel,    // one-hot ratio select
    output logic                            ratioValid   // code is a legal ratio
);

    // ratio code map
    // codes 0..5 are 64..512 fs, 6..9 are 50..400 fs; above 9 selects nothing
    always_comb
    begin
        ratioSel = '0;
        for (int i = 0; i < RATIO_SEL_WIDTH; i++)
        begin
            if (ratioCode == 4'(i))
            begin
                ratioSel[i] = 1'b1;
            end
        end
        ratioValid = (ratioCode <= RATIO_CODE_MAX);
    end

endmodule : ratio_code_decoder

// file: clock_ratio_boost_config_regs.sv
// top: ratio and boost configuration registers with soft reset
`timescale 1ns/100ps
module clock_ratio_boost_config_regs
    import ratio_boost_pkg::*;
(
    input  wire logic                       core_clk,           // 250 MHz core clock
    input  wire logic                       rst_b,              // async reset, active low
    input  wire reg_req_type                regReq,             // control port request
    output logic      [7:0]                 rdData,             // read data, registered
    input  wire logic                       detectValid,        // detector has a ratio
    input  wire logic [3:0]                 detectedRatioCode,  // ratio from detector
    input  wire logic                       boostFaultLatched,  // boost fault held
    output logic      [3:0]                 activeRatioCode,    // ratio used by clocking
    output logic      [RATIO_SEL_WIDTH-1:0] activeRatioSel,     // one-hot active ratio
    output logic                            activeRatioValid,   // active code legal
    output logic                            autoRatioDetectEn,  // detector enable
    output boost_ctrl_type                  boostCtrl,          // boost analog controls
    output logic                            recoveryPulse,      // one recovery attempt
    output logic                            softResetPulse      // soft reset start
);

    // behaviour of the bank, seen from the control port
    // - a write lands on the edge that takes the strobe and shows right after that edge
    // - a read answers one edge after its strobe, and the data then holds
    // - reads and writes may come back to back; no wait states are inserted
    // - reserved bits store what software wrote and read it back unchanged
    // - the soft reset key raises one pulse, and the registers return on the next edge
    // - writes to the three config registers in the pulse cycle are lost, so software waits one cycle after the key
    // - any other value at the soft reset address is ignored
    // - the detector only touches the ratio code field while auto mode is on
    // - in auto mode the detector beats a software code write in the same cycle
    // - the recovery trigger is not stored, and its address reads as zero
    // - the trigger is refused unless manual recovery is chosen and a fault is held
    // - codes 10 to 15 are accepted but flagged invalid toward the clocking logic
    // - the boost controls come straight from flops, so they never glitch on a write

    // register storage and next values
    logic [7:0] clockRatioConfig_reg;   // auto bit plus ratio code
    logic [7:0] clockRatioConfig_next;
    logic [7:0] boostConfigA_reg;       // speed, discharge, pwm mode, freq
    logic [7:0] boostConfigA_next;
    logic [7:0] boostConfigB_reg;       // recovery mode, gm select
    logic [7:0] boostConfigB_next;
    logic [7:0] rdData_reg;             // read data holding
    logic [7:0] rdData_next;
    logic       recovery_reg;           // recovery pulse
    logic       recovery_next;
    logic       softReset_reg;          // soft reset pulse
    logic       softReset_next;

    // decoded write strobes
    logic wrRatio;
    logic wrBoostA;
    logic wrBoostB;
    logic wrSoftReset;
    logic wrFault;

    // address match shared by write decode
    function automatic logic hit(input reg_req_type req, input logic [7:0] addr);
        hit = req.wrEn && (req.addr == addr);
    endfunction : hit

    // strobes are pure decodes of the request; no state here
    always_comb
    begin
        wrRatio     = hit(regReq, ADDR_CLOCK_RATIO_CONFIG);
        wrBoostA    = hit(regReq, ADDR_BOOST_CONFIG_A);
        wrBoostB    = hit(regReq, ADDR_BOOST_CONFIG_B);
        wrFault     = hit(regReq, ADDR_FAULT_CONTROL);
        // soft reset key
        // only the exact key value starts a reset; other values are ignored
        wrSoftReset = hit(regReq, ADDR_SOFTWARE_RESET_CMD) && (regReq.wrData == SOFT_RESET_KEY);
    end

    // next-state for all configuration registers
    // writes first, then the detector, then soft reset: later assignments win
    always_comb
    begin
        // start from the held values so every path assigns every output
        clockRatioConfig_next = clockRatioConfig_reg;
        boostConfigA_next     = boostConfigA_reg;
        boostConfigB_next     = boostConfigB_reg;
        // software writes store every bit, reserved bits read back as written
        if (wrRatio)
        begin
            clockRatioConfig_next = regReq.wrData;
        end
        if (wrBoostA)
        begin
            boostConfigA_next = regReq.wrData;
        end
        if (wrBoostB)
        begin
            boostConfigB_next = regReq.wrData;
        end
        // detected code stored
        // detector update wins over a same-cycle software code write in auto mode
        if (clockRatioConfig_next[AUTO_RATIO_BIT] && detectValid)
        begin
            clockRatioConfig_next[RATIO_CODE_MSB:0] = detectedRatioCode;
        end
        // soft reset restores
        // soft reset overrides any same-cycle write to the config registers
        if (softReset_reg)
        begin
            clockRatioConfig_next = RST_CLOCK_RATIO_CONFIG;
            boostConfigA_next     = RST_BOOST_CONFIG_A;
            boostConfigB_next     = RST_BOOST_CONFIG_B;
        end
    end

    // next-state for pulses and read data
    always_comb
    begin
        // one recovery attempt
        // trigger only acts while boost is in manual recovery and a fault is held
        recovery_next  = wrFault && regReq.wrData[MANUAL_TRIG_BIT]
                         && boostConfigB_reg[MANUAL_RCV_BIT] && boostFaultLatched;
        softReset_next = wrSoftReset;
        // the read mux only moves on a read strobe, so rdData holds between reads
        rdData_next    = rdData_reg;
        if (regReq.rdEn)
        begin
            case (regReq.addr)
                ADDR_CLOCK_RATIO_CONFIG: rdData_next = clockRatioConfig_reg;
                ADDR_BOOST_CONFIG_A:     rdData_next = boostConfigA_reg;
                ADDR_BOOST_CONFIG_B:     rdData_next = boostConfigB_reg;
                // soft reset register and unmapped addresses read as zero
                default:                 rdData_next = 8'h00;
            endcase
        end
    end

    // register the configuration group
    // async reset only at power-up; soft reset goes through the next-state path instead
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clockRatioConfig_reg <= RST_CLOCK_RATIO_CONFIG;
            boostConfigA_reg     <= RST_BOOST_CONFIG_A;
            boostConfigB_reg     <= RST_BOOST_CONFIG_B;
        end
        else
        begin
            // normal operation: take the computed next values
            clockRatioConfig_reg <= clockRatioConfig_next;
            boostConfigA_reg     <= boostConfigA_next;
            boostConfigB_reg     <= boostConfigB_next;
        end
    end

    // register the pulse and read data group
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // pulses idle low, read data cleared
            rdData_reg    <= 8'h00;
            recovery_reg  <= 1'b0;
            softReset_reg <= 1'b0;
        end
        else
        begin
            // pulses last one cycle because their next values are strobes
            rdData_reg    <= rdData_next;
            recovery_reg  <= recovery_next;
            softReset_reg <= softReset_next;
        end
    end

    assign autoRatioDetectEn = clockRatioConfig_reg[AUTO_RATIO_BIT];
    // manual code used
    // in auto mode the field already holds the detected code, so one path serves both
    assign activeRatioCode = clockRatioConfig_reg[RATIO_CODE_MSB:0];

    // one-hot decode of the active code for the clock ratio logic
    ratio_code_decoder i_ratio_code_decoder
    (
        .ratioCode  (activeRatioCode),
        .ratioSel   (activeRatioSel),
        .ratioValid (activeRatioValid)
    );

    // boost controls straight from register bits
    always_comb
    begin
        boostCtrl.highSideDriveSpeed = boostConfigA_reg[DRIVE_SPEED_LSB +: 2];
        boostCtrl.dischargeSwitchEn  = boostConfigA_reg[DISCHARGE_BIT];
        boostCtrl.pwmOnlyN           = boostConfigA_reg[PWM_ONLY_N_BIT];
        boostCtrl.boostFreqSel       = boostConfigA_reg[FREQ_SEL_BIT];
        boostCtrl.boostFaultManualRecovery = boostConfigB_reg[MANUAL_RCV_BIT];
        boostCtrl.errorAmpGmSel      = boostConfigB_reg[GM_SEL_LSB +: 2];
    end

    // outputs straight from flops, no combinational path from the bus
    assign rdData         = rdData_reg;
    assign recoveryPulse  = recovery_reg;
    assign softResetPulse = softReset_reg;

endmodule : clock_ratio_boost_config_regs

// file: clock_ratio_boost_config_regs_props.sv
// checker: port timing relations of the ratio and boost config bank
`timescale 1ns/100ps
module clock_ratio_boost_config_regs_props
    import ratio_boost_pkg::*;
(
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire reg_req_type                regReq,
    input wire logic [7:0]                 rdData,
    input wire logic                       detectValid,
    input wire logic [3:0]                 detectedRatioCode,
    input wire logic                       boostFaultLatched,
    input wire logic [3:0]                 activeRatioCode,
    input wire logic [RATIO_SEL_WIDTH-1:0] activeRatioSel,
    input wire logic                       activeRatioValid,
    input wire logic                       autoRatioDetectEn,
    input wire boost_ctrl_type             boostCtrl,
    input wire logic                       recoveryPulse,
    input wire logic                       softResetPulse
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // decoded writes; a soft reset pulse overrides the three config writes, not the key or the trigger
    logic wrRatio;
    logic wrA;
    logic wrB;
    logic wrKey;
    logic trigOk;
    assign wrRatio = regReq.wrEn && regReq.addr == 8'h14;
    assign wrA     = regReq.wrEn && regReq.addr == 8'h15;
    assign wrB     = regReq.wrEn && regReq.addr == 8'h16;
    assign wrKey   = regReq.wrEn && regReq.addr == 8'hff && regReq.wrData == 8'h00;
    assign trigOk  = regReq.wrEn && regReq.addr == 8'h12 && regReq.wrData[3]
                     && boostCtrl.boostFaultManualRecovery && boostFaultLatched;
    a_key_pulse:
    assert property (1'b1 |=> softResetPulse == $past(wrKey))
        else $error("soft reset pulse wrong");
    a_reset_restores:
    assert property (softResetPulse |=> activeRatioCode == 4'h1 && autoRatioDetectEn
        && boostCtrl == 8'h18) else $error("soft reset left a register changed");
    a_auto_load:
    assert property (autoRatioDetectEn && detectValid && !wrRatio && !softResetPulse
        |=> activeRatioCode == $past(detectedRatioCode)) else $error("detected code not stored");
    a_manual_hold:
    assert property (!autoRatioDetectEn && !wrRatio && !softResetPulse
        |=> $stable(activeRatioCode)) else $error("manual ratio code moved");
    a_ratio_write:
    assert property (wrRatio && !softResetPulse && !(regReq.wrData[4] && detectValid)
        |=> {autoRatioDetectEn, activeRatioCode} == $past(regReq.wrData[4:0]))
        else $error("ratio write lost");
    a_ratio_decode:
    assert property (activeRatioValid == (activeRatioCode <= 4'h9) && activeRatioSel
        == (activeRatioValid ? (10'h1 << activeRatioCode) : 10'h0)) else $error("bad decode");
    a_boost_a_write:
    assert property (wrA && !softResetPulse |=> boostCtrl[7:3] ==
        {$past(regReq.wrData[7:6]), $past(regReq.wrData[2:0])}) else $error("boost a wrong");
    a_boost_b_write:
    assert property (wrB && !softResetPulse |=> boostCtrl[2:0] ==
        {$past(regReq.wrData[3]), $past(regReq.wrData[1:0])}) else $error("boost b wrong");
    a_recovery_once:
    assert property (1'b1 |=> recoveryPulse == $past(trigOk)) else $error("recovery pulse wrong");
endmodule : clock_ratio_boost_config_regs_props

// file: clock_ratio_boost_config_regs_tb.sv
// testbench: register access, detector, boost controls, recovery and soft reset
`timescale 1ns/100ps
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin badCount++; \
    $display("MISMATCH t=%0t act=%0h exp=%0h", $time, act, exp); end end
module clock_ratio_boost_config_regs_tb
    import ratio_boost_pkg::*;
;
    logic                 core_clk = 1'b0;
    logic                 rst_b = 1'b0;             // held low for five edges
    reg_req_type          regReq = '0;              // control port request
    logic                 detectValid = 1'b0;       // detector strobe
    logic [3:0]           detectedRatioCode = 4'h0;
    logic                 boostFaultLatched = 1'b0;
    logic [7:0]           rdData;
    logic [3:0]           activeRatioCode;
    logic [9:0]           activeRatioSel;
    logic                 activeRatioValid;
    logic                 autoRatioDetectEn;
    boost_ctrl_type       boostCtrl;
    logic                 recoveryPulse;
    logic                 softResetPulse;
    int                   badCount = 0;
    int                   checks = 0;
    // 250 MHz core clock
    always #2 core_clk = ~core_clk;
    clock_ratio_boost_config_regs i_clock_ratio_boost_config_regs (
        .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData),
        .detectValid(detectValid), .detectedRatioCode(detectedRatioCode),
        .boostFaultLatched(boostFaultLatched), .activeRatioCode(activeRatioCode),
        .activeRatioSel(activeRatioSel), .activeRatioValid(activeRatioValid),
        .autoRatioDetectEn(autoRatioDetectEn), .boostCtrl(boostCtrl),
        .recoveryPulse(recoveryPulse), .softResetPulse(softResetPulse));
    // one-cycle write strobe; outputs settle just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        regReq.wrEn <= 1'b0;
        #1;
    endtask : wr
    // read strobe; registered data compared once it has landed
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(posedge core_clk);
        regReq.rdEn <= 1'b0;
        #1;
        `CHK(rdData, e)
    endtask : rd
    // one detector strobe carrying a code
    task automatic det(input logic [3:0] c);
        @(posedge core_clk);
        detectValid <= 1'b1;
        detectedRatioCode <= c;
        @(posedge core_clk);
        detectValid <= 1'b0;
        #1;
    endtask : det
    // closing report, the only exit of the run
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    initial
    begin
        logic [7:0] d;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        `CHK(boostCtrl, 8'h18)
        rd(8'h14, 8'h11);
        rd(8'h15, 8'h03);
        rd(8'h16, 8'h00);
        rd(8'hff, 8'h00);
        rd(8'h20, 8'h00);
        // auto mode: the detected code lands in the ratio field
        det(4'h7);
        `CHK(autoRatioDetectEn, 1'b1)
        rd(8'h14, 8'h17);
        // every code in manual mode, with the detector firing to be ignored
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h14, 8'(i));
            det(4'h2);
            `CHK(activeRatioCode, 4'(i))
            `CHK(autoRatioDetectEn, 1'b0)
            `CHK(activeRatioValid, 1'(i <= 9))
            `CHK(activeRatioSel, (i <= 9) ? (10'h1 << i) : 10'h0)
        end
        // all boost field values; reserved bits must read back as written
        for (int i = 0; i < 8; i++)
        begin
            d = {i[1:0], 3'h2, i[2:0]};
            wr(8'h15, d);
            `CHK(boostCtrl[7:3], {d[7:6], d[2:0]})
            rd(8'h15, d);
            d = {4'h5, i[2], 1'b1, i[1:0]};
            wr(8'h16, d);
            `CHK(boostCtrl[2:0], {d[3], d[1:0]})
            rd(8'h16, d);
        end
        // trigger fires only with manual policy and a latched fault
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h16, {4'h0, i[0], 3'h0});
            @(posedge core_clk);
            boostFaultLatched <= i[1];
            wr(8'h12, 8'h08);
            `CHK(recoveryPulse, 1'(i == 3))
            @(posedge core_clk);
            #1;
            `CHK(recoveryPulse, 1'b0)
        end
        rd(8'h12, 8'h00);
        // wrong key ignored, right key restores all registers
        wr(8'h14, 8'h05);
        wr(8'hff, 8'h01);
        `CHK(softResetPulse, 1'b0)
        wr(8'hff, 8'h00);
        `CHK(softResetPulse, 1'b1)
        rd(8'h14, 8'h11);
        rd(8'h15, 8'h03);
        rd(8'h16, 8'h00);
        `CHK(softResetPulse, 1'b0)
        results();
    end
endmodule : clock_ratio_boost_config_regs_tb
bind clock_ratio_boost_config_regs clock_ratio_boost_config_regs_props i_props (
    .core_clk(core_clk), .rst_b(rst_b), .regReq(regReq), .rdData(rdData),
    .detectValid(detectValid), .detectedRatioCode(detectedRatioCode),
    .boostFaultLatched(boostFaultLatched), .activeRatioCode(activeRatioCode),
    .activeRatioSel(activeRatioSel), .activeRatioValid(activeRatioValid),
    .autoRatioDetectEn(autoRatioDetectEn), .boostCtrl(boostCtrl),
    .recoveryPulse(recoveryPulse), .softResetPulse(softResetPulse));
